// ### rtl/ibs_pkg.sv
// Shared constants and types for the I2C master byte sequencer.
// Assumes a single clk_in domain for software-facing logic.
package ibs_pkg;

  // ****************************************************************
  // Widths and counts
  // ****************************************************************
  localparam int unsigned RELOAD_W      = 7;
  localparam int unsigned BYTE_W        = 8;
  localparam logic [3:0]  LAST_DATA_BIT = 4'h7;
  localparam logic [3:0]  ACK_BIT_SLOT  = 4'h8;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [7:0]          RST_BYTE  = 8'h00;
  localparam logic [3:0]          RST_BITS  = 4'h0;
  localparam logic [RELOAD_W-1:0] RST_COUNT = 7'h00;
  localparam logic                RST_FLAG  = 1'b0;
  localparam logic                RST_REL   = 1'b1;

  // ****************************************************************
  // Sequencer states
  // ****************************************************************
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_TX_LOW,
    ST_TX_WAITH,
    ST_TX_HIGH,
    ST_RX_LOW,
    ST_RX_WAITH,
    ST_RX_HIGH,
    ST_ACK_LOW,
    ST_ACK_WAITH,
    ST_ACK_HIGH,
    ST_STOP_SDA,
    ST_STOP_LOW,
    ST_STOP_WAITH,
    ST_STOP_HIGH,
    ST_STOP_WAITP,
    ST_STOP_TAIL
  } ibs_state_t;

endpackage

// ### rtl/ibs_byte_sequencer.sv
// I2C master byte engine: transmit, receive, acknowledge and stop sequences.
// Assumes open-drain pads outside; q_phase_clk_in ticks once per counter phase.
//
// Notes on behaviour
// - Buffer write sets full flag, starts transfer
// - Bit placed after SCL low; low/high periods
// - Eighth falling edge clears full, releases SDA
// - Ninth falling edge samples acknowledge status
// - After ninth clock: interrupt, hold SCL low
// - Address sent as seven bits plus direction
// - Busy buffer write discarded, collision flag set
// - Receive request ignored unless port idle
// - Receive toggles SCL, shifts SDA in
// - Eighth receive edge: copy, flags, back idle
// - Buffer read clears full flag when idle
// - Overflow when byte completes while full
// - Ack sequence drives bit, low then high
// - Ack end: SCL low, enable clear, idle
// - Stop: SDA low, count, release SCL, SDA
// - Stop seen sets flag, then interrupt
// - Counter waits for SCL high, then reloads
// - Reset disables port, aborts transfer
// - Start/stop flags cleared; stop interrupts
// - SDA compared with intended level
// - Counter reloads seven bits, counts down
// - Counter decrements on each phase tick, holds at zero
// - Collision halts, clears full, releases lines
`timescale 1ns/1ps

module ibs_byte_sequencer (
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       q_phase_clk_in,
  input  wire logic       port_enable_in,
  input  wire logic [6:0] rate_reload_in,
  input  wire logic       buf_wr_in,
  input  wire logic [7:0] buf_wdata_in,
  input  wire logic       buf_rd_in,
  input  wire logic       receive_request_in,
  input  wire logic       ack_seq_req_in,
  input  wire logic       ack_data_bit_in,
  input  wire logic       stop_req_in,
  input  wire logic       write_collision_flag_clr_in,
  input  wire logic       int_clr_in,
  input  wire logic       ovf_clr_in,
  input  wire logic       bcol_clr_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe_n_out,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  output logic [7:0]      xfer_buffer_out,
  output logic            buffer_full_flag_out,
  output logic            write_collision_flag_out,
  output logic            ack_status_flag_out,
  output logic            port_interrupt_flag_out,
  output logic            receive_overflow_flag_out,
  output logic            bus_collision_flag_out,
  output logic            start_detected_out,
  output logic            stop_detected_out,
  output logic            receive_request_bit_out,
  output logic            ack_sequence_enable_out,
  output logic            stop_sequence_enable_out,
  output logic            idle_out
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  ibs_pkg::ibs_state_t state_reg;
  ibs_pkg::ibs_state_t state_next;
  logic [6:0]          cnt_reg;
  logic [7:0]          shift_reg;
  logic [3:0]          bits_reg;
  logic                tick_tgl_reg;
  logic                tick_s1_reg;
  logic                tick_s2_reg;
  logic                tick_s3_reg;
  logic                scl_s1_reg;
  logic                scl_s2_reg;
  logic                sda_s1_reg;
  logic                sda_s2_reg;
  logic                sda_prev_reg;
  logic                tick;
  logic                tmo;
  logic                cnt_load;
  logic                wr_ok;
  logic                ev_tx_start;
  logic                ev_fall;
  logic                ev_ack_sample;
  logic                ev_rx_start;
  logic                ev_rx_sample;
  logic                ev_rx_done;
  logic                ev_ack_start;
  logic                ev_ack_done;
  logic                ev_stop_start;
  logic                ev_stop_done;
  logic                ev_bcol;
  logic                sda_upd;
  logic                sda_val;

  // ****************************************************************
  // Counter phase ticks and pin synchronisers
  // ****************************************************************
  // One toggle per phase edge; a toggle survives the crossing where a pulse would not
  always_ff @(posedge q_phase_clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_tgl_reg <= ibs_pkg::RST_FLAG;
    end else begin
      tick_tgl_reg <= ~tick_tgl_reg;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_s1_reg  <= ibs_pkg::RST_FLAG;
      tick_s2_reg  <= ibs_pkg::RST_FLAG;
      tick_s3_reg  <= ibs_pkg::RST_FLAG;
      scl_s1_reg   <= ibs_pkg::RST_REL;
      scl_s2_reg   <= ibs_pkg::RST_REL;
      sda_s1_reg   <= ibs_pkg::RST_REL;
      sda_s2_reg   <= ibs_pkg::RST_REL;
      sda_prev_reg <= ibs_pkg::RST_REL;
    end else begin
      tick_s1_reg  <= tick_tgl_reg;
      tick_s2_reg  <= tick_s1_reg;
      tick_s3_reg  <= tick_s2_reg;
      scl_s1_reg   <= scl_in;
      scl_s2_reg   <= scl_s1_reg;
      sda_s1_reg   <= sda_in;
      sda_s2_reg   <= sda_s1_reg;
      sda_prev_reg <= sda_s2_reg;
    end
  end

  assign tick = tick_s2_reg ^ tick_s3_reg;
  assign tmo  = (cnt_reg == ibs_pkg::RST_COUNT);

  // ****************************************************************
  // Next state and events
  // ****************************************************************
  always_comb begin
    state_next    = state_reg;
    cnt_load      = 1'b0;
    ev_tx_start   = 1'b0;
    ev_fall       = 1'b0;
    ev_ack_sample = 1'b0;
    ev_rx_start   = 1'b0;
    ev_rx_sample  = 1'b0;
    ev_rx_done    = 1'b0;
    ev_ack_start  = 1'b0;
    ev_ack_done   = 1'b0;
    ev_stop_start = 1'b0;
    ev_stop_done  = 1'b0;
    ev_bcol       = 1'b0;
    sda_upd       = 1'b0;
    sda_val       = 1'b1;
    wr_ok         = buf_wr_in && (state_reg == ibs_pkg::ST_IDLE) && port_enable_in;
    if (!port_enable_in) begin
      state_next = ibs_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        ibs_pkg::ST_IDLE: begin
          if (wr_ok) begin
            state_next  = ibs_pkg::ST_TX_LOW;
            ev_tx_start = 1'b1;
            cnt_load    = 1'b1;
            sda_upd     = 1'b1;
            sda_val     = buf_wdata_in[7];
          end else if (stop_req_in) begin
            state_next    = ibs_pkg::ST_STOP_SDA;
            ev_stop_start = 1'b1;
            sda_upd       = 1'b1;
            sda_val       = 1'b0;
          end else if (ack_seq_req_in) begin
            state_next   = ibs_pkg::ST_ACK_LOW;
            ev_ack_start = 1'b1;
            cnt_load     = 1'b1;
            sda_upd      = 1'b1;
            sda_val      = ack_data_bit_in;
          end else if (receive_request_in) begin
            state_next  = ibs_pkg::ST_RX_LOW;
            ev_rx_start = 1'b1;
            cnt_load    = 1'b1;
            sda_upd     = 1'b1;
          end
        end
        ibs_pkg::ST_TX_LOW: begin
          if (tmo) state_next = ibs_pkg::ST_TX_WAITH;
        end
        ibs_pkg::ST_TX_WAITH: begin
          if (scl_s2_reg) begin
            state_next = ibs_pkg::ST_TX_HIGH;
            cnt_load   = 1'b1;
          end
        end
        ibs_pkg::ST_TX_HIGH: begin
          if (sda_oe_n_out && !sda_s2_reg && bits_reg != ibs_pkg::ACK_BIT_SLOT) begin
            state_next = ibs_pkg::ST_IDLE;
            ev_bcol    = 1'b1;
          end else if (tmo && bits_reg == ibs_pkg::ACK_BIT_SLOT) begin
            state_next    = ibs_pkg::ST_IDLE;
            ev_ack_sample = 1'b1;
          end else if (tmo) begin
            state_next = ibs_pkg::ST_TX_LOW;
            ev_fall    = 1'b1;
            cnt_load   = 1'b1;
            sda_upd    = 1'b1;
            sda_val    = (bits_reg == ibs_pkg::LAST_DATA_BIT) ? 1'b1 : shift_reg[6];
          end
        end
        ibs_pkg::ST_RX_LOW: begin
          if (tmo) state_next = ibs_pkg::ST_RX_WAITH;
        end
        ibs_pkg::ST_RX_WAITH: begin
          if (scl_s2_reg) begin
            state_next = ibs_pkg::ST_RX_HIGH;
            cnt_load   = 1'b1;
          end
        end
        ibs_pkg::ST_RX_HIGH: begin
          if (tmo) begin
            ev_rx_sample = 1'b1;
            if (bits_reg == ibs_pkg::LAST_DATA_BIT) begin
              state_next = ibs_pkg::ST_IDLE;
              ev_rx_done = 1'b1;
            end else begin
              state_next = ibs_pkg::ST_RX_LOW;
              cnt_load   = 1'b1;
            end
          end
        end
        ibs_pkg::ST_ACK_LOW: begin
          if (tmo) state_next = ibs_pkg::ST_ACK_WAITH;
        end
        ibs_pkg::ST_ACK_WAITH: begin
          if (scl_s2_reg) begin
            state_next = ibs_pkg::ST_ACK_HIGH;
            cnt_load   = 1'b1;
          end
        end
        ibs_pkg::ST_ACK_HIGH: begin
          if (sda_oe_n_out && !sda_s2_reg) begin
            state_next = ibs_pkg::ST_IDLE;
            ev_bcol    = 1'b1;
          end else if (tmo) begin
            state_next  = ibs_pkg::ST_IDLE;
            ev_ack_done = 1'b1;
          end
        end
        ibs_pkg::ST_STOP_SDA: begin
          if (!sda_s2_reg) begin
            state_next = ibs_pkg::ST_STOP_LOW;
            cnt_load   = 1'b1;
          end
        end
        ibs_pkg::ST_STOP_LOW: begin
          if (tmo) state_next = ibs_pkg::ST_STOP_WAITH;
        end
        ibs_pkg::ST_STOP_WAITH: begin
          if (scl_s2_reg) begin
            state_next = ibs_pkg::ST_STOP_HIGH;
            cnt_load   = 1'b1;
          end
        end
        ibs_pkg::ST_STOP_HIGH: begin
          if (tmo) begin
            state_next = ibs_pkg::ST_STOP_WAITP;
            sda_upd    = 1'b1;
          end
        end
        ibs_pkg::ST_STOP_WAITP: begin
          if (sda_s2_reg && scl_s2_reg) begin
            state_next = ibs_pkg::ST_STOP_TAIL;
            cnt_load   = 1'b1;
          end
        end
        ibs_pkg::ST_STOP_TAIL: begin
          if (tmo) begin
            state_next   = ibs_pkg::ST_IDLE;
            ev_stop_done = 1'b1;
          end
        end
        default: begin
          state_next = ibs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= ibs_pkg::ST_IDLE;
      idle_out  <= 1'b1;
    end else begin
      state_reg <= state_next;
      idle_out  <= (state_next == ibs_pkg::ST_IDLE);
    end
  end

  // ****************************************************************
  // SCL rate counter
  // ****************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      cnt_reg <= ibs_pkg::RST_COUNT;
    end else if (!port_enable_in) begin
      cnt_reg <= ibs_pkg::RST_COUNT;
    end else if (cnt_load) begin
      cnt_reg <= rate_reload_in;
    end else if (tick && !tmo) begin
      cnt_reg <= cnt_reg - 7'h01;
    end
  end

  // ****************************************************************
  // Line drivers
  // ****************************************************************
  // Pads are only ever pulled low; a high comes from the pull-up
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      scl_out      <= 1'b0;
      sda_out      <= 1'b0;
      scl_oe_n_out <= ibs_pkg::RST_REL;
      sda_oe_n_out <= ibs_pkg::RST_REL;
    end else begin
      scl_out <= 1'b0;
      sda_out <= 1'b0;
      if (!port_enable_in || ev_bcol || ev_stop_done) begin
        scl_oe_n_out <= 1'b1;
      end else if (state_next == ibs_pkg::ST_IDLE) begin
        if (state_reg != ibs_pkg::ST_IDLE) scl_oe_n_out <= 1'b0;
      end else begin
        case (state_next)
          ibs_pkg::ST_TX_WAITH, ibs_pkg::ST_TX_HIGH, ibs_pkg::ST_RX_WAITH,
          ibs_pkg::ST_RX_HIGH, ibs_pkg::ST_ACK_WAITH, ibs_pkg::ST_ACK_HIGH,
          ibs_pkg::ST_STOP_WAITH, ibs_pkg::ST_STOP_HIGH, ibs_pkg::ST_STOP_WAITP,
          ibs_pkg::ST_STOP_TAIL: begin
            scl_oe_n_out <= 1'b1;
          end
          default: begin
            scl_oe_n_out <= 1'b0;
          end
        endcase
      end
      if (!port_enable_in || ev_bcol) begin
        sda_oe_n_out <= 1'b1;
      end else if (sda_upd) begin
        sda_oe_n_out <= sda_val;
      end
    end
  end

  // ****************************************************************
  // Shift register, bit count and buffer
  // ****************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      shift_reg       <= ibs_pkg::RST_BYTE;
      bits_reg        <= ibs_pkg::RST_BITS;
      xfer_buffer_out <= ibs_pkg::RST_BYTE;
    end else begin
      if (ev_tx_start) begin
        shift_reg       <= buf_wdata_in;
        bits_reg        <= ibs_pkg::RST_BITS;
        xfer_buffer_out <= buf_wdata_in;
      end else if (ev_fall) begin
        shift_reg <= {shift_reg[6:0], 1'b0};
        bits_reg  <= bits_reg + 4'h1;
      end else if (ev_rx_start) begin
        bits_reg <= ibs_pkg::RST_BITS;
      end else if (ev_rx_sample) begin
        shift_reg <= {shift_reg[6:0], sda_s2_reg};
        bits_reg  <= bits_reg + 4'h1;
      end
      if (ev_rx_done) begin
        xfer_buffer_out <= {shift_reg[6:0], sda_s2_reg};
      end
    end
  end

  // ****************************************************************
  // Status flags; a set always wins over a clear in the same cycle
  // ****************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      buffer_full_flag_out      <= ibs_pkg::RST_FLAG;
      write_collision_flag_out  <= ibs_pkg::RST_FLAG;
      ack_status_flag_out       <= ibs_pkg::RST_FLAG;
      port_interrupt_flag_out   <= ibs_pkg::RST_FLAG;
      receive_overflow_flag_out <= ibs_pkg::RST_FLAG;
      bus_collision_flag_out    <= ibs_pkg::RST_FLAG;
    end else begin
      if (!port_enable_in || ev_bcol) begin
        buffer_full_flag_out <= 1'b0;
      end else if (ev_tx_start || ev_rx_done) begin
        buffer_full_flag_out <= 1'b1;
      end else if (ev_fall && bits_reg == ibs_pkg::LAST_DATA_BIT) begin
        buffer_full_flag_out <= 1'b0;
      end else if (buf_rd_in && state_reg == ibs_pkg::ST_IDLE) begin
        buffer_full_flag_out <= 1'b0;
      end
      if (buf_wr_in && port_enable_in && !wr_ok) begin
        write_collision_flag_out <= 1'b1;
      end else if (write_collision_flag_clr_in) begin
        write_collision_flag_out <= 1'b0;
      end
      if (ev_ack_sample) begin
        ack_status_flag_out <= sda_s2_reg;
      end
      if (ev_ack_sample || ev_rx_done || ev_stop_done) begin
        port_interrupt_flag_out <= 1'b1;
      end else if (port_enable_in && scl_s2_reg && sda_s2_reg && !sda_prev_reg &&
                   start_detected_out) begin
        port_interrupt_flag_out <= 1'b1;
      end else if (int_clr_in) begin
        port_interrupt_flag_out <= 1'b0;
      end
      if (ev_rx_done && buffer_full_flag_out) begin
        receive_overflow_flag_out <= 1'b1;
      end else if (ovf_clr_in) begin
        receive_overflow_flag_out <= 1'b0;
      end
      if (ev_bcol) begin
        bus_collision_flag_out <= 1'b1;
      end else if (bcol_clr_in) begin
        bus_collision_flag_out <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Sequence enables and bus condition monitor
  // ****************************************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      receive_request_bit_out  <= ibs_pkg::RST_FLAG;
      ack_sequence_enable_out  <= ibs_pkg::RST_FLAG;
      stop_sequence_enable_out <= ibs_pkg::RST_FLAG;
    end else begin
      if (ev_rx_start) begin
        receive_request_bit_out <= 1'b1;
      end else if (ev_rx_done || !port_enable_in) begin
        receive_request_bit_out <= 1'b0;
      end
      if (ev_ack_start) begin
        ack_sequence_enable_out <= 1'b1;
      end else if (ev_ack_done || ev_bcol || !port_enable_in) begin
        ack_sequence_enable_out <= 1'b0;
      end
      if (ev_stop_start) begin
        stop_sequence_enable_out <= 1'b1;
      end else if (ev_stop_done || !port_enable_in) begin
        stop_sequence_enable_out <= 1'b0;
      end
    end
  end

  // Own and foreign conditions alike; software uses these to judge a free bus
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      start_detected_out <= ibs_pkg::RST_FLAG;
      stop_detected_out  <= ibs_pkg::RST_FLAG;
    end else if (!port_enable_in) begin
      start_detected_out <= 1'b0;
      stop_detected_out  <= 1'b0;
    end else if (scl_s2_reg && sda_prev_reg && !sda_s2_reg) begin
      start_detected_out <= 1'b1;
      stop_detected_out  <= 1'b0;
    end else if (scl_s2_reg && !sda_prev_reg && sda_s2_reg) begin
      start_detected_out <= 1'b0;
      stop_detected_out  <= 1'b1;
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  a_bf_on_write: assert property (wr_ok |=> buffer_full_flag_out)
    else $error("full flag not set by buffer write");
  a_write_collision_flag_busy: assert property (
    buf_wr_in && port_enable_in && state_reg != ibs_pkg::ST_IDLE
    |=> write_collision_flag_out && $stable(xfer_buffer_out))
    else $error("busy write not flagged or not discarded");
  a_bf_eighth: assert property (ev_fall && bits_reg == ibs_pkg::LAST_DATA_BIT
    |=> !buffer_full_flag_out && sda_oe_n_out && !scl_oe_n_out)
    else $error("eighth edge did not clear full flag and free SDA");
  a_ack_sample: assert property (ev_ack_sample
    |=> ack_status_flag_out == $past(sda_s2_reg))
    else $error("ack status does not match sampled SDA");
  a_ninth_hold: assert property (ev_ack_sample
    |=> port_interrupt_flag_out && !scl_oe_n_out [*2])
    else $error("ninth clock did not interrupt and hold SCL low");
  a_rx_ignored: assert property (
    receive_request_in && state_reg != ibs_pkg::ST_IDLE && !receive_request_bit_out
    |=> !receive_request_bit_out)
    else $error("receive request taken while busy");
  a_rx_done: assert property (ev_rx_done
    |=> !receive_request_bit_out && buffer_full_flag_out && idle_out)
    else $error("receive completion flags wrong");
  a_rx_overflow: assert property (ev_rx_done && buffer_full_flag_out
    |=> receive_overflow_flag_out)
    else $error("overflow not flagged");
  a_bcol_release: assert property (ev_bcol
    |=> scl_oe_n_out && sda_oe_n_out && !buffer_full_flag_out && bus_collision_flag_out)
    else $error("collision did not release lines");
  a_lines_low: assert property (!scl_out && !sda_out)
    else $error("line driven high");
  a_port_off: assert property (!port_enable_in
    |=> !start_detected_out && !stop_detected_out && state_reg == ibs_pkg::ST_IDLE)
    else $error("disabled port kept state");
  a_ack_end: assert property (ev_ack_done
    |=> !ack_sequence_enable_out && !scl_oe_n_out && idle_out)
    else $error("ack sequence did not end cleanly");

endmodule

// ### tb/ibs_slave_model.sv
// Behavioural I2C slave for the byte sequencer bench.
// Assumes pull-ups on both wires; pull_out high means this slave holds SDA low.
`timescale 1ns/1ps
module ibs_slave_model (
  input  wire logic       rst_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       send_in,
  input  wire logic       ack_in,
  input  wire logic [7:0] tx_byte_in,
  output logic            pull_out,
  output logic [7:0]      rx_byte_out
);
  int n;
  always @(posedge scl_in or posedge rst_in) begin
    if (rst_in) begin
      n <= 0;
      rx_byte_out <= 8'h00;
    end else begin
      n <= n + 1;
      if (n < 8) rx_byte_out <= {rx_byte_out[6:0], sda_in};
    end
  end
  // Data moves after SCL falls or at reset, so within a transfer the master sees it stable while high
  always @(negedge scl_in or posedge rst_in) begin
    if (rst_in) pull_out <= send_in & ~tx_byte_in[7];
    else if (send_in) pull_out <= (n < 8) && !tx_byte_in[7 - (n % 8)];
    else pull_out <= (n == 8) && ack_in;
  end
endmodule

// ### tb/ibs_byte_sequencer_bench.sv
// Self-checking bench for the I2C master byte sequencer.
// Assumes open-drain wires with pull-ups, resolved here from all enables.
`timescale 1ns/1ps
module ibs_byte_sequencer_bench;
  logic clk = 0, rst = 1, qclk = 0, en = 1, ackd = 0, srst = 0, send = 0, sack = 0;
  logic [7:0] wd = 8'h00, stx = 8'h00, srx;
  logic [8:0] req = 9'h000;
  logic scl_o, scl_oe_n, sda_o, sda_oe_n, pull, full, write_collision_flag, acks, intf, ovf, bcol;
  logic sta, stp, receive_request_bit, ack_sequence_enable, stop_sequence_enable, idle;
  logic [7:0] buffer;
  wire scl = scl_oe_n ? 1'b1 : scl_o;
  wire sda = (sda_oe_n ? 1'b1 : sda_o) & ~pull;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  initial forever #2.5 clk = ~clk;
  initial begin #1.3; forever #3 qclk = ~qclk; end
  ibs_byte_sequencer u_dut (.clk_in(clk), .rst_in(rst), .q_phase_clk_in(qclk),
    .port_enable_in(en), .rate_reload_in(7'h02), .buf_wr_in(req[0]), .buf_wdata_in(wd),
    .buf_rd_in(req[1]), .receive_request_in(req[2]), .ack_seq_req_in(req[3]),
    .ack_data_bit_in(ackd), .stop_req_in(req[4]), .write_collision_flag_clr_in(req[5]), .int_clr_in(req[6]),
    .ovf_clr_in(req[7]), .bcol_clr_in(req[8]), .scl_in(scl), .sda_in(sda), .scl_out(scl_o),
    .scl_oe_n_out(scl_oe_n), .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .xfer_buffer_out(buffer),
    .buffer_full_flag_out(full), .write_collision_flag_out(write_collision_flag), .ack_status_flag_out(acks),
    .port_interrupt_flag_out(intf), .receive_overflow_flag_out(ovf),
    .bus_collision_flag_out(bcol), .start_detected_out(sta), .stop_detected_out(stp),
    .receive_request_bit_out(receive_request_bit), .ack_sequence_enable_out(ack_sequence_enable),
    .stop_sequence_enable_out(stop_sequence_enable), .idle_out(idle));
  ibs_slave_model u_slave (.rst_in(srst), .scl_in(scl), .sda_in(sda), .send_in(send),
    .ack_in(sack), .tx_byte_in(stx), .pull_out(pull), .rx_byte_out(srx));
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Hangs are cut short well beyond the longest sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      n_mismatch++;
    end
  endtask
  // One-cycle software pulse on the selected request lines
  task automatic op(input logic [8:0] r, input logic [7:0] d);
    @(posedge clk) #1 req = r;
    wd = d;
    @(posedge clk) #1 req = 9'h000;
  endtask
  task automatic slave(input logic s, input logic a, input logic [7:0] b);
    send = s; sack = a; stx = b;
    #1 srst = 1;
    #1 srst = 0;
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 3000 && idle !== 1'b1; i++) @(posedge clk);
    #1;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    #1 rst = 0;
    repeat (3) @(posedge clk);
    chk("idle", 1, {scl_o, sda_o, idle, full, intf, scl_oe_n, sda_oe_n} === 7'h13);
    slave(0, 1, 8'h00);
    op(9'h001, 8'hA5);
    chk("full", 1, full);
    op(9'h001, 8'h5A);
    chk("write_collision_flag", 1, write_collision_flag);
    op(9'h004, 8'h00);
    chk("receive_request_bit", 0, receive_request_bit);
    wait_idle();
    chk("addr", 8'hA5, srx);
    chk("ack_status_flag", 0, acks);
    chk("int", 1, intf);
    chk("scl", 0, scl_oe_n);
    chk("full", 0, full);
    chk("buf", 8'hA5, buffer);
    op(9'h1E0, 8'h00);
    slave(0, 0, 8'h00);
    op(9'h001, 8'hC3);
    wait_idle();
    chk("ack_status_flag", 1, acks);
    chk("data", 8'hC3, srx);
    for (int k = 0; k < 2; k++) begin
      slave(1, 0, k ? 8'h96 : 8'h3C);
      op(9'h004, 8'h00);
      chk("receive_request_bit", 1, receive_request_bit);
      wait_idle();
      chk("rxbuf", k ? 8'h96 : 8'h3C, buffer);
      chk("rxflags", 8'h03, {receive_request_bit, full, intf});
      chk("ovf", k, ovf);
    end
    op(9'h002, 8'h00);
    chk("full", 0, full);
    slave(0, 0, 8'h00);
    ackd = 1;
    op(9'h008, 8'h00);
    chk("ack_sequence_enable", 1, ack_sequence_enable);
    wait_idle();
    chk("ack", 8'h00, {ack_sequence_enable, scl_oe_n});
    op(9'h1E0, 8'h00);
    op(9'h010, 8'h00);
    wait_idle();
    chk("stop", 8'h0F, {stop_sequence_enable, stp, intf, scl_oe_n, sda_oe_n});
    chk("bcol", 0, bcol);
    @(posedge clk) #1 en = 0;
    @(posedge clk) #1 en = 1;
    chk("stopdet", 0, stp);
    // Another master grabs SDA while SCL is high, then fights our leading one
    op(9'h040, 8'h00);
    slave(1, 0, 8'h00);
    op(9'h001, 8'h80);
    wait_idle();
    chk("bcol", 8'h13, {bcol, full, intf, scl_oe_n, sda_oe_n});
    chk("start", 1, sta);
    slave(0, 0, 8'h00);
    repeat (4) @(posedge clk);
    #1;
    chk("busstop", 8'h03, {sta, stp, intf});
    wrap_up();
  end
endmodule
